/* File: common/mss_pkg.sv */
// Package for the motion status monitor: register offsets, bit positions, widths.
// Assumes a single 40 MHz controller clock and a word-wide register read port.
package mss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_SYSTEM_STATUS = 16'h9008;
  localparam logic [15:0] ADDR_SPECIAL_PORT  = 16'h9012;
  localparam logic [15:0] WORD_ZERO          = 16'h0000;

  // ----------------------------------------------------------------
  // System status word fields
  // ----------------------------------------------------------------
  localparam int BIT_NEG_PULSE = 14;
  localparam int BIT_POS_PULSE = 12;
  localparam int BIT_MODE      = 8;
  localparam int BIT_BELT      = 4;
  localparam int BIT_HOMECHK   = 3;
  localparam int BIT_OVERTRAV  = 2;
  localparam int BIT_CREEP     = 1;
  localparam int BIT_LIMIT     = 0;

  // ----------------------------------------------------------------
  // Special port monitor word fields
  // ----------------------------------------------------------------
  localparam int BIT_BAND_T2 = 14;
  localparam int BIT_BAND_T1 = 13;

  localparam int POS_W  = 32;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // Raw pin levels, sampled through synchronisers
  typedef struct packed {
    logic neg_pulse_level;
    logic pos_pulse_level;
    logic mode_selector_state;
    logic belt_intact;
    logic homecheck_input;
    logic overtravel_input;
    logic creep_input;
    logic limit_input;
  } mss_pins_t;

  // Build fitting options of the unit
  typedef struct packed {
    logic has_mode_switch;
    logic has_homecheck;
    logic has_overtravel;
    logic has_creep;
    logic has_limit;
  } mss_fit_t;

  // Positioning data from the motion core, same clock
  typedef struct packed {
    logic signed [POS_W-1:0] current_pos;
    logic signed [POS_W-1:0] target_pos1;
    logic signed [POS_W-1:0] target_pos2;
    logic signed [POS_W-1:0] band_size;
  } mss_pos_t;

endpackage

/* File: design/mss_monitor.sv */
// Function
// R1: status bit 14 follows the negative command pulse input level
// R2: status bit 12 follows the positive command pulse input level
// R3: status bit 8 is 0 in automatic mode, 1 in manual mode
// R4: without a mode selector switch the mode bit always reads 1
// R5: status bit 4 reads 0 on broken belt, 1 when belt normal
// R6: status bit 3 mirrors home-check sensor, 0 when function absent
// R7: status bit 2 mirrors overtravel sensor, 0 when not fitted
// R8: status bit 1 mirrors creep sensor, 0 when not fitted
// R9: status bit 0 mirrors limit sensor, 0 when not fitted
// R10: monitor bit 14 set while position within target 2 plus or minus band
// R11: monitor bit 13 set while position within target 1 plus or minus band
// R12: band flags are meaningful only after home return completes
// R13: band flags keep updating after homing even with servo off
// R14: band flags apply only in valve mode 2 or solenoid modes
// R15: system status word is read at address 9008 hex
// R16: homing done flag is 0 before home return, 1 once finished
// R17: unusable bits read 0; host writes to these words are ignored
// R18: band boundaries count as inside; signed position arithmetic
//
// Read-only status register bank of the actuator controller.
// Assumes the frame handler presents a read address and takes data one cycle later.
`timescale 1ns/1ps

module mss_monitor (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire mss_pkg::mss_pins_t      pins_async,
  input  wire mss_pkg::mss_fit_t       fit,
  input  wire mss_pkg::mss_pos_t       pos,
  input  wire logic                    homing_done,
  input  wire logic                    band_mode_active,
  input  wire logic                    rd_en,
  input  wire logic                    wr_en,
  input  wire logic [15:0]             addr,
  input  wire logic [15:0]             wr_data,
  output logic      [15:0]             rd_data,
  output logic                         rd_valid,
  output logic                         addr_hit
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  mss_pkg::mss_pins_t sync1;
  mss_pkg::mss_pins_t pins;
  mss_pkg::mss_pins_t next_sync1;
  mss_pkg::mss_pins_t next_pins;

  always_comb begin
    next_sync1 = pins_async;
    next_pins  = sync1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= '0;
      pins  <= '0;
    end else begin
      sync1 <= next_sync1;
      pins  <= next_pins;
    end
  end

  // ----------------------------------------------------------------
  // Band comparators
  // ----------------------------------------------------------------
  // Extend by one bit so target plus band cannot wrap at the range ends
  function automatic logic in_band(input logic signed [mss_pkg::POS_W-1:0] cur,
                                   input logic signed [mss_pkg::POS_W-1:0] tgt,
                                   input logic signed [mss_pkg::POS_W-1:0] band);
    logic signed [mss_pkg::POS_W:0] lo;
    logic signed [mss_pkg::POS_W:0] hi;
    logic signed [mss_pkg::POS_W:0] c;
    lo = {tgt[mss_pkg::POS_W-1], tgt} - {band[mss_pkg::POS_W-1], band};
    hi = {tgt[mss_pkg::POS_W-1], tgt} + {band[mss_pkg::POS_W-1], band};
    c  = {cur[mss_pkg::POS_W-1], cur};
    in_band = (c >= lo) && (c <= hi); // R18
  endfunction

  logic band_flag_target1;
  logic band_flag_target2;
  logic next_band1;
  logic next_band2;

  // Flags ignore servo state: only homing and mode qualify them
  always_comb begin
    next_band1 = 1'b0;
    next_band2 = 1'b0;
    if (homing_done && band_mode_active) begin // R12 R13 R14 R16
      next_band1 = in_band(pos.current_pos, pos.target_pos1, pos.band_size); // R11
      next_band2 = in_band(pos.current_pos, pos.target_pos2, pos.band_size); // R10
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      band_flag_target1 <= 1'b0;
      band_flag_target2 <= 1'b0;
    end else begin
      band_flag_target1 <= next_band1;
      band_flag_target2 <= next_band2;
    end
  end

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  logic [15:0] system_status_word;
  logic [15:0] special_port_monitor_word;

  always_comb begin
    system_status_word = mss_pkg::WORD_ZERO; // R17
    system_status_word[mss_pkg::BIT_NEG_PULSE] = pins.neg_pulse_level; // R1
    system_status_word[mss_pkg::BIT_POS_PULSE] = pins.pos_pulse_level; // R2
    system_status_word[mss_pkg::BIT_MODE] =
      fit.has_mode_switch ? pins.mode_selector_state : 1'b1; // R3 R4
    system_status_word[mss_pkg::BIT_BELT] = pins.belt_intact; // R5
    system_status_word[mss_pkg::BIT_HOMECHK] =
      fit.has_homecheck & pins.homecheck_input; // R6
    system_status_word[mss_pkg::BIT_OVERTRAV] =
      fit.has_overtravel & pins.overtravel_input; // R7
    system_status_word[mss_pkg::BIT_CREEP] = fit.has_creep & pins.creep_input; // R8
    system_status_word[mss_pkg::BIT_LIMIT] = fit.has_limit & pins.limit_input; // R9
    special_port_monitor_word = mss_pkg::WORD_ZERO; // R17
    special_port_monitor_word[mss_pkg::BIT_BAND_T2] = band_flag_target2; // R10
    special_port_monitor_word[mss_pkg::BIT_BAND_T1] = band_flag_target1; // R11
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] next_rd_data;
  logic        next_rd_valid;
  logic        hit_sys;
  logic        hit_spm;

  // Writes are accepted silently; nothing here is writable
  always_comb begin
    hit_sys       = (addr == mss_pkg::ADDR_SYSTEM_STATUS); // R15
    hit_spm       = (addr == mss_pkg::ADDR_SPECIAL_PORT);
    addr_hit      = (rd_en | wr_en) & (hit_sys | hit_spm);
    next_rd_valid = rd_en;
    next_rd_data  = mss_pkg::WORD_ZERO;
    if (rd_en && hit_sys) begin
      next_rd_data = system_status_word; // R15
    end else if (rd_en && hit_spm) begin
      next_rd_data = special_port_monitor_word;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data  <= mss_pkg::WORD_ZERO;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

endmodule

/* File: testbench/mss_host.sv */
// Host model: issues one-cycle word reads and captures each answer.
// Assumes go is a one-cycle pulse per read.
`timescale 1ns/1ps
module mss_host (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] where,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  output logic             rd_en,
  output logic [15:0]      addr,
  output logic             got,
  output logic [15:0]      word
);
  always @(posedge clk) begin
    rd_en <= go;
    // Idle address keeps changing so a stale value never looks like a request
    addr <= go ? where : ~addr;
    got <= rd_valid;
    word <= rd_data;
  end
endmodule

/* File: testbench/mss_monitor_props.sv */
// Checker for the status monitor read port and word contents.
// Assumes it is bound to mss_monitor; one clock, sync reset.
`timescale 1ns/1ps
module mss_monitor_props (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire mss_pkg::mss_pins_t pins_async,
  input wire mss_pkg::mss_fit_t  fit,
  input wire logic               homing_done,
  input wire logic               rd_en,
  input wire logic [15:0]        addr,
  input wire logic [15:0]        rd_data,
  input wire logic               rd_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pins must sit still long enough to clear the synchronisers
  sequence s_st;
    $stable(pins_async)[*4] ##0 rd_en && addr == 16'h9008;
  endsequence
  property p_valid; rd_en |=> rd_valid; endproperty
  a_valid: assert property (p_valid) else $error("no read answer");
  property p_idle; !rd_en |=> !rd_valid && rd_data == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("answer without read");
  property p_neg; s_st |=> rd_data[14] == $past(pins_async.neg_pulse_level); endproperty
  a_neg: assert property (p_neg) else $error("neg pulse bit");
  property p_pos; s_st |=> rd_data[12] == $past(pins_async.pos_pulse_level); endproperty
  a_pos: assert property (p_pos) else $error("pos pulse bit");
  property p_mode;
    s_st |=> rd_data[8] == ($past(pins_async.mode_selector_state) | !fit.has_mode_switch);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bit");
  property p_belt; s_st |=> rd_data[4] == $past(pins_async.belt_intact); endproperty
  a_belt: assert property (p_belt) else $error("belt bit");
  property p_sens; s_st |=> rd_data[3:0] == $past(pins_async[3:0] & fit[3:0]); endproperty
  a_sens: assert property (p_sens) else $error("sensor bits");
  property p_free; rd_en && addr == 16'h9008 |=> (rd_data & 16'hAEE0) == 16'h0000; endproperty
  a_free: assert property (p_free) else $error("unused status bit set");
  property p_home;
    (!homing_done)[*3] ##0 rd_en && addr == 16'h9012 |=> rd_data == 16'h0000;
  endproperty
  a_home: assert property (p_home) else $error("band flag before homing");
endmodule
bind mss_monitor mss_monitor_props mss_monitor_props_i (.clk(clk), .sys_rst(sys_rst),
  .pins_async(pins_async), .fit(fit), .homing_done(homing_done), .rd_en(rd_en),
  .addr(addr), .rd_data(rd_data), .rd_valid(rd_valid));

/* File: testbench/test_motion_status_monitor.sv */
// Bench for the status monitor: pin and fit table, then band and port cases.
// Assumes the host model mss_host drives the read port.
`timescale 1ns/1ps
module test_motion_status_monitor;
  typedef struct packed {
    mss_pkg::mss_fit_t  f;
    mss_pkg::mss_pins_t p;
    logic [15:0]        e;
  } mss_row_t;
  localparam mss_pkg::mss_pos_t P1 = {32'h64, 32'h5A, 32'h6F, 32'hA};
  localparam mss_pkg::mss_pos_t P2 = {32'hFFFFFFFB, 32'h5, 32'hFFFFFFF1, 32'hA};
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  mss_pkg::mss_pins_t pins = '0;
  mss_pkg::mss_fit_t  fit = '0;
  mss_pkg::mss_pos_t  pos = '0;
  logic               homing_done = 1'b0;
  logic               band_mode_active = 1'b0;
  logic               go = 1'b0;
  logic               wr_en = 1'b0;
  logic [15:0]        where = 16'h0000;
  logic               rd_en, rd_valid, got, addr_hit;
  logic [15:0]        addr, rd_data, word;
  int                 fails = 0;
  int                 comparisons = 0;
  mss_row_t rows [5] = '{'{5'h1F, 8'hFF, 16'h511F}, '{5'h00, 8'hFF, 16'h5110},
    '{5'h1F, 8'h00, 16'h0000}, '{5'h00, 8'h00, 16'h0100}, '{5'h1F, 8'hA5, 16'h4105}};
  always #12.5 clk = ~clk;
  mss_host mss_host_i (.clk(clk), .go(go), .where(where), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_en(rd_en), .addr(addr), .got(got), .word(word));
  mss_monitor mss_monitor_i (.clk(clk), .sys_rst(sys_rst), .pins_async(pins), .fit(fit),
    .pos(pos), .homing_done(homing_done), .band_mode_active(band_mode_active),
    .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wr_data(16'hFFFF), .rd_data(rd_data),
    .rd_valid(rd_valid), .addr_hit(addr_hit));
  task automatic report_and_stop();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write strobe rides on the read cycle itself, so it must change nothing
  task automatic rd(logic [15:0] a, logic w);
    int n;
    @(negedge clk);
    go = 1'b1;
    where = a;
    @(negedge clk);
    go = 1'b0;
    wr_en = w;
    chk("addr_hit", {15'h0000, addr_hit},
      {15'h0000, a == mss_pkg::ADDR_SYSTEM_STATUS || a == mss_pkg::ADDR_SPECIAL_PORT});
    @(negedge clk);
    wr_en = 1'b0;
    n = 0;
    while (got !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    if (got !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic band(logic h, logic m, mss_pkg::mss_pos_t p, logic [15:0] e);
    homing_done = h;
    band_mode_active = m;
    pos = p;
    repeat (3) @(negedge clk);
    rd(16'h9012, 1'b0);
    chk("monitor word", word, e);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    chk("rd_data", rd_data, 16'h0000);
    foreach (rows[i]) begin
      fit = rows[i].f;
      pins = rows[i].p;
      repeat (4) @(negedge clk);
      rd(16'h9008, 1'b0);
      chk("status word", word, rows[i].e);
    end
    rd(16'h9008, 1'b1);
    chk("status after write", word, 16'h4105);
    rd(16'h9010, 1'b0);
    chk("unmapped", word, 16'h0000);
    band(1'b1, 1'b0, P1, 16'h0000);
    band(1'b1, 1'b1, P1, 16'h2000);
    band(1'b1, 1'b1, P2, 16'h6000);
    band(1'b0, 1'b1, P2, 16'h0000);
    // Reset again in mid-run: outputs clear, pins re-enter through the synchronisers
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    chk("rd_data after reset", rd_data, 16'h0000);
    repeat (4) @(negedge clk);
    rd(16'h9008, 1'b0);
    chk("status after reset", word, 16'h4105);
    report_and_stop();
  end
endmodule
